/* File: logic/mcktc_pkg.sv */
// package of constants for the main clock and tick controller
// Notes on behaviour
// - slow select 0: cpu clock at full rate
// - slow divider codes divide by 2,4,8,16
// - bit 7 routes cpu clock to pin
// - clock-out pin stops in active halt
// - tick period 16000/32000/80000/200000 oscillator cycles
// - new tick select applies from next period
// - tick flag bit 0 set each period
// - reading control register clears tick flag
// - tick with enable raises interrupt request
// - enable set makes halt become active halt
// - wait keeps running, tick wakes from wait
// - active halt: counter runs, registers frozen except tick flag
// - full halt freezes all, tick cannot wake
// - divider and timer run independently; clock-out follows the divider pulses
// - beeper drives one of three tones
// - beep codes off, 2k, 1k, 500 Hz
// - control register at 002Ch, resets zero
package mcktc_pkg;
   // register addresses
   localparam logic [7:0] ADDR_CTRL_STATUS = 8'h2C;
   localparam logic [7:0] ADDR_BEEP_CTRL   = 8'h2D;
   localparam logic [7:0] CTRL_RESET       = 8'h00;
   localparam logic [7:0] BEEP_RESET       = 8'h00;
   // control/status field positions
   localparam int BIT_CLK_OUT   = 7;
   localparam int BIT_DIV_HI    = 6;
   localparam int BIT_DIV_LO    = 5;
   localparam int BIT_SLOW      = 4;
   localparam int BIT_TB_HI     = 3;
   localparam int BIT_TB_LO     = 2;
   localparam int BIT_TICK_IE   = 1;
   localparam int BIT_TICK_FLAG = 0;
   // tick periods in oscillator cycles
   localparam logic [17:0] TB_PERIOD_0 = 18'h0_3E80;
   localparam logic [17:0] TB_PERIOD_1 = 18'h0_7D00;
   localparam logic [17:0] TB_PERIOD_2 = 18'h1_3880;
   localparam logic [17:0] TB_PERIOD_3 = 18'h3_0D40;
   // cpu divider terminal counts: divide by 2, 4, 8, 16
   localparam logic [3:0]  CPU_DIV_LIM_0 = 4'h1;
   localparam logic [3:0]  CPU_DIV_LIM_1 = 4'h3;
   localparam logic [3:0]  CPU_DIV_LIM_2 = 4'h7;
   localparam logic [3:0]  CPU_DIV_LIM_3 = 4'hF;
   // beep half periods at 8 MHz: 2 kHz, 1 kHz, 500 Hz
   localparam logic [13:0] BEEP_HALF_1 = 14'h07D0;
   localparam logic [13:0] BEEP_HALF_2 = 14'h0FA0;
   localparam logic [13:0] BEEP_HALF_3 = 14'h1F40;
   // power modes seen by the clock controller
   typedef enum logic [1:0] {PM_RUN, PM_WAIT, PM_ACTIVE_HALT, PM_HALT} mcktc_pm_e;
endpackage

/* File: logic/mcktc_cfg_if.sv */
// interface carrying the control settings to the clock divider
`timescale 1ns/1ps
interface mcktc_cfg_if;
   logic       slow_mode_select;
   logic [1:0] slow_divider_field;
   logic       run;
   logic       cpu_clk_en;
   modport ctrl (output slow_mode_select, output slow_divider_field, output run,
                 input cpu_clk_en);
   modport div  (input slow_mode_select, input slow_divider_field, input run,
                 output cpu_clk_en);
endinterface

/* File: logic/mcktc_cpu_div.sv */
// cpu clock divider producing a one-cycle clock enable
`timescale 1ns/1ps
module mcktc_cpu_div
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // settings and result
   mcktc_cfg_if.div cfg
);
   logic [3:0] cnt_r;
   logic [3:0] lim;

   // divide-by limit minus one: 1,3,7,15
   always_comb
   begin
      unique case (cfg.slow_divider_field)
         2'b00: lim = mcktc_pkg::CPU_DIV_LIM_0;
         2'b01: lim = mcktc_pkg::CPU_DIV_LIM_1;
         2'b10: lim = mcktc_pkg::CPU_DIV_LIM_2;
         2'b11: lim = mcktc_pkg::CPU_DIV_LIM_3;
      endcase
   end

   // counter runs only in slow mode outside both halts, else held at zero
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || !cfg.slow_mode_select || !cfg.run)
         cnt_r <= 4'h0;
      else if (cnt_r >= lim)
         cnt_r <= 4'h0;
      else
         cnt_r <= cnt_r + 4'h1;
   end

   // full rate in normal mode, one pulse per period in slow mode
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         cfg.cpu_clk_en <= 1'b0;
      else
         cfg.cpu_clk_en <= cfg.run & (!cfg.slow_mode_select | (cnt_r >= lim));
   end
endmodule // mcktc_cpu_div

/* File: logic/mcktc_top.sv */
// main clock controller: cpu clock divider, clock out, tick timer, beeper
`timescale 1ns/1ps
module mcktc_top
(
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   // register port
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output logic      [7:0] rdata,
   // power mode control from the core
   input  wire logic       wait_req,
   input  wire logic       halt_req,
   input  wire logic       wakeup_ext,
   output logic      [1:0] power_mode,
   // clocks and events out
   output logic            cpu_clk_en,
   output logic            cpu_clk_out,
   output logic            clk_out_oe,
   output logic            tick_irq,
   output logic            beep_out,
   output logic            beep_oe
);
   localparam logic [1:0] BEEP_RST = mcktc_pkg::BEEP_RESET[1:0];
   logic [7:0]          ctrl_r;
   logic [1:0]          beep_ctrl_r;
   logic [17:0]         tb_cnt_r;
   logic [17:0]         tb_limit_r;
   logic                tick;
   logic [13:0]         beep_cnt_r;
   logic [13:0]         beep_half;
   mcktc_pkg::mcktc_pm_e pm_r;
   logic                regs_live;
   logic [17:0]         tb_sel_limit;
   logic                cpu_pulse;

   mcktc_cfg_if cfg ();

   // registers are only writable while the core runs
   assign regs_live = (pm_r == mcktc_pkg::PM_RUN) || (pm_r == mcktc_pkg::PM_WAIT);

   // settings to divider; halts stop cpu clocks
   assign cfg.slow_mode_select   = ctrl_r[mcktc_pkg::BIT_SLOW];
   assign cfg.slow_divider_field = ctrl_r[mcktc_pkg::BIT_DIV_HI:mcktc_pkg::BIT_DIV_LO];
   assign cfg.run                = regs_live;
   assign cpu_pulse              = cfg.cpu_clk_en;

   mcktc_cpu_div u_div
   (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .cfg     (cfg)
   );

   // time-base period selection
   always_comb
   begin
      unique case (ctrl_r[mcktc_pkg::BIT_TB_HI:mcktc_pkg::BIT_TB_LO])
         2'b00: tb_sel_limit = mcktc_pkg::TB_PERIOD_0;
         2'b01: tb_sel_limit = mcktc_pkg::TB_PERIOD_1;
         2'b10: tb_sel_limit = mcktc_pkg::TB_PERIOD_2;
         2'b11: tb_sel_limit = mcktc_pkg::TB_PERIOD_3;
      endcase
   end

   // tick at the last cycle of the active period
   assign tick = (pm_r != mcktc_pkg::PM_HALT) && (tb_cnt_r == tb_limit_r - 18'h1);

   // free-running counter; limit latched only at period end so changes wait
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         tb_cnt_r   <= 18'h0;
         tb_limit_r <= mcktc_pkg::TB_PERIOD_0;
      end
      else if (pm_r == mcktc_pkg::PM_HALT)
         tb_cnt_r <= tb_cnt_r;
      else if (tick)
      begin
         tb_cnt_r   <= 18'h0;
         tb_limit_r <= tb_sel_limit;
      end
      else
         tb_cnt_r <= tb_cnt_r + 18'h1;
   end

   // power mode sequencer
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         pm_r <= mcktc_pkg::PM_RUN;
      else
      begin
         unique case (pm_r)
            mcktc_pkg::PM_RUN:
            begin
               if (halt_req)
                  pm_r <= ctrl_r[mcktc_pkg::BIT_TICK_IE] ? mcktc_pkg::PM_ACTIVE_HALT
                                                         : mcktc_pkg::PM_HALT;
               else if (wait_req)
                  pm_r <= mcktc_pkg::PM_WAIT;
            end
            mcktc_pkg::PM_WAIT:
               if (wakeup_ext || (tick && ctrl_r[mcktc_pkg::BIT_TICK_IE]))
                  pm_r <= mcktc_pkg::PM_RUN;
            mcktc_pkg::PM_ACTIVE_HALT:
               if (wakeup_ext || (tick && ctrl_r[mcktc_pkg::BIT_TICK_IE]))
                  pm_r <= mcktc_pkg::PM_RUN;
            mcktc_pkg::PM_HALT:
               if (wakeup_ext)
                  pm_r <= mcktc_pkg::PM_RUN;
         endcase
      end
   end

   // control register; frozen in either halt except the tick flag, read clears flag unless tick coincides
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         ctrl_r <= mcktc_pkg::CTRL_RESET;
      else
      begin
         if (regs_live && wr && addr == mcktc_pkg::ADDR_CTRL_STATUS)
            ctrl_r[7:1] <= wdata[7:1];  // flag is not writable
         if (tick)
            ctrl_r[mcktc_pkg::BIT_TICK_FLAG] <= 1'b1;
         else if (regs_live && rd && addr == mcktc_pkg::ADDR_CTRL_STATUS)
            ctrl_r[mcktc_pkg::BIT_TICK_FLAG] <= 1'b0;
      end
   end

   // beep control register, reserved bits ignored
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         beep_ctrl_r <= BEEP_RST;
      else if (regs_live && wr && addr == mcktc_pkg::ADDR_BEEP_CTRL)
         beep_ctrl_r <= wdata[1:0];
   end

   // read data one cycle later; unmapped reads zero
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
         rdata <= 8'h00;
      else if (rd && addr == mcktc_pkg::ADDR_CTRL_STATUS)
         rdata <= ctrl_r;
      else if (rd && addr == mcktc_pkg::ADDR_BEEP_CTRL)
         rdata <= {6'h00, beep_ctrl_r};
      else
         rdata <= 8'h00;
   end

   // beep half period by code
   always_comb
   begin
      unique case (beep_ctrl_r)
         2'b01:   beep_half = mcktc_pkg::BEEP_HALF_1;
         2'b10:   beep_half = mcktc_pkg::BEEP_HALF_2;
         2'b11:   beep_half = mcktc_pkg::BEEP_HALF_3;
         default: beep_half = mcktc_pkg::BEEP_HALF_1;
      endcase
   end

   // square wave at 50% duty; still runs in active halt, stops in full halt
   always_ff @(posedge sys_clk)
   begin
      if (!nrst || beep_ctrl_r == 2'b00)
      begin
         beep_cnt_r <= 14'h0;
         beep_out   <= 1'b0;
      end
      else if (pm_r != mcktc_pkg::PM_HALT)
      begin
         if (beep_cnt_r >= beep_half - 14'h1)
         begin
            beep_cnt_r <= 14'h0;
            beep_out   <= ~beep_out;
         end
         else
            beep_cnt_r <= beep_cnt_r + 14'h1;
      end
   end

   // registered outputs: enables, clock out, interrupt, mode
   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         beep_oe     <= 1'b0;
         clk_out_oe  <= 1'b0;
         cpu_clk_out <= 1'b0;
         cpu_clk_en  <= 1'b0;
         tick_irq    <= 1'b0;
         power_mode  <= 2'b00;
      end
      else
      begin
         beep_oe    <= (beep_ctrl_r != 2'b00);
         clk_out_oe <= ctrl_r[mcktc_pkg::BIT_CLK_OUT];
         // clock out toggles on cpu pulses, which stop in both halts
         if (ctrl_r[mcktc_pkg::BIT_CLK_OUT] && cpu_pulse && regs_live)
            cpu_clk_out <= ~cpu_clk_out;
         cpu_clk_en <= cpu_pulse;
         tick_irq   <= tick && ctrl_r[mcktc_pkg::BIT_TICK_IE];
         power_mode <= pm_r;
      end
   end
endmodule // mcktc_top

/* File: testbench/mcktc_chk_sva.sv */
// port assertions for the clock and tick controller
`timescale 1ns/1ps
module mcktc_chk
(
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       nrst,
   // register port
   input wire logic [7:0] addr,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   // power and outputs
   input wire logic       wakeup_ext,
   input wire logic [1:0] power_mode,
   input wire logic       cpu_clk_en,
   input wire logic       cpu_clk_out,
   input wire logic       clk_out_oe,
   input wire logic       tick_irq,
   input wire logic       beep_out,
   input wire logic       beep_oe
);
   logic in_run, in_ah, in_halt, wr_bp;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // mode decodes kept short so the properties stay readable
   assign in_run  = power_mode == mcktc_pkg::PM_RUN;
   assign in_ah   = power_mode == mcktc_pkg::PM_ACTIVE_HALT;
   assign in_halt = power_mode == mcktc_pkg::PM_HALT;
   assign wr_bp   = wr && addr == mcktc_pkg::ADDR_BEEP_CTRL;
   rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
      else $error("read data outside read cycle");
   oe_mirror_a: assert property (rd && addr == mcktc_pkg::ADDR_CTRL_STATUS |=>
      rdata[7] == clk_out_oe) else $error("pin enable differs from bit 7");
   tick_pulse_a: assert property (tick_irq |=> !tick_irq)
      else $error("tick longer than one cycle");
   // mode output lags the sequencer by one cycle, so the wake-up that counts is one back
   halt_hold_a: assert property (in_halt && !$past(wakeup_ext) |=> in_halt)
      else $error("halt left without wake-up");
   wake_tick_a: assert property (tick_irq && !in_run && !in_halt |->
      ##[0:3] in_run) else $error("tick did not wake");
   clk_out_halt_a: assert property (in_ah [*3] |-> $stable(cpu_clk_out))
      else $error("clock out toggles in active halt");
   clk_en_run_a: assert property (in_run && !cpu_clk_en |->
      ##[1:20] (cpu_clk_en || !in_run)) else $error("cpu clock enable stalled");
   beep_oe_write_a: assert property ($changed(beep_oe) |->
      $past(wr_bp) || $past(wr_bp, 2)) else $error("beep enable moved without write");
   // main scenarios reached
   cov_tick: cover property (tick_irq);
   cov_ah: cover property (in_ah ##1 in_run);
   cov_halt: cover property (in_halt ##1 in_run);
endmodule // mcktc_chk
bind mcktc_top mcktc_chk u_chk
(
   .sys_clk     (sys_clk),
   .nrst        (nrst),
   .addr        (addr),
   .wr          (wr),
   .rd          (rd),
   .rdata       (rdata),
   .wakeup_ext  (wakeup_ext),
   .power_mode  (power_mode),
   .cpu_clk_en  (cpu_clk_en),
   .cpu_clk_out (cpu_clk_out),
   .clk_out_oe  (clk_out_oe),
   .tick_irq    (tick_irq),
   .beep_out    (beep_out),
   .beep_oe     (beep_oe)
);

/* File: testbench/tb_mcktc_top.sv */
// self-checking bench for the clock and tick controller
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin bad_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, a, b); end end
module tb_mcktc_top;
   logic        sys_clk = 0, nrst = 0, wr = 0, rd = 0, rd_q = 0, beep_q = 0;
   logic        wait_req = 0, halt_req = 0, wakeup_ext = 0, co = 0;
   logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
   logic [1:0]  power_mode, c;
   logic        cpu_clk_en, cpu_clk_out, clk_out_oe, tick_irq, beep_out, beep_oe;
   logic [15:0] e, expq[$];
   int          bad_count = 0, tests_run = 0, seed = 32'h36b882fe, n, k, r;
   time         t0;
   mcktc_top u_dut
   (
      .sys_clk     (sys_clk),
      .nrst        (nrst),
      .addr        (addr),
      .wdata       (wdata),
      .wr          (wr),
      .rd          (rd),
      .rdata       (rdata),
      .wait_req    (wait_req),
      .halt_req    (halt_req),
      .wakeup_ext  (wakeup_ext),
      .power_mode  (power_mode),
      .cpu_clk_en  (cpu_clk_en),
      .cpu_clk_out (cpu_clk_out),
      .clk_out_oe  (clk_out_oe),
      .tick_irq    (tick_irq),
      .beep_out    (beep_out),
      .beep_oe     (beep_oe)
   );
   always #5 sys_clk = ~sys_clk;
   // delayed strobe marks the cycle in which read data stand
   always @(posedge sys_clk)
   begin
      rd_q <= rd;
      beep_q <= beep_out;
   end
   // oldest note holds mask and expected value of the pending read
   always @(negedge sys_clk)
      if (rd_q)
      begin
         e = expq.pop_front();
         `CHK(rdata & e[15:8], e[7:0])
      end
   function automatic logic ev(input int sel);
      return sel == 0 ? cpu_clk_en : sel == 1 ? tick_irq : beep_out ^ beep_q;
   endfunction
   // bounded wait for the next event on one probe, n is cycles taken
   task automatic waitev(input int sel, input int lim);
      for (n = 1; n <= lim; n++)
      begin
         @(negedge sys_clk);
         if (ev(sel) === 1'b1) break;
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      expq.push_back({m, x});
      @(posedge sys_clk);
      rd <= 1'b0;
   endtask
   // one-cycle core request, then let the mode settle
   task automatic pm(input logic w, input logic h);
      @(posedge sys_clk);
      wait_req <= w;
      halt_req <= h;
      @(posedge sys_clk);
      wait_req <= 1'b0;
      halt_req <= 1'b0;
      repeat (3) @(negedge sys_clk);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // watchdog sized about 30000 cycles above the four tick periods of the run
   initial
   begin
      repeat (110000) @(posedge sys_clk);
      bad_count++;
      results();
   end
   initial
   begin
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      rreg(8'h2C, 8'hFF, 8'h00);
      rreg(8'h2D, 8'hFF, 8'h00);
      rreg(8'h2E, 8'hFF, 8'h00);
      waitev(0, 40);
      waitev(0, 40);
      `CHK(n, 1)
      r = $random(seed);
      // divider codes in a random starting order, bit 0 write must not stick
      for (k = 0; k < 4; k++)
      begin
         c = k[1:0] + r[1:0];
         wreg(8'h2C, {1'b1, c, 5'b10001});
         rreg(8'h2C, 8'hFF, {1'b1, c, 5'b10000});
         waitev(0, 40);
         waitev(0, 40);
         `CHK(n, 2 << c)
         `CHK(clk_out_oe, 1'b1)
      end
      wreg(8'h2C, 8'h02);
      rreg(8'h2C, 8'hFE, 8'h02);
      `CHK(clk_out_oe, 1'b0)
      // tones measured by half period, the slowest only enabled
      for (k = 1; k < 3; k++)
      begin
         wreg(8'h2D, k[7:0]);
         waitev(2, 9000);
         waitev(2, 9000);
         `CHK(n, k == 1 ? mcktc_pkg::BEEP_HALF_1 : mcktc_pkg::BEEP_HALF_2)
      end
      wreg(8'h2D, 8'h03);
      `CHK(beep_oe, 1'b1)
      wreg(8'h2D, 8'h00);
      repeat (3) @(negedge sys_clk);
      `CHK(beep_oe, 1'b0)
      waitev(1, 17000);
      waitev(1, 17000);
      t0 = $time;
      `CHK(n, mcktc_pkg::TB_PERIOD_0)
      rreg(8'h2C, 8'h01, 8'h01);
      rreg(8'h2C, 8'h01, 8'h00);
      // whole-byte write with clock out on, so the halt freeze is visible on the pin
      wreg(8'h2C, 8'h86);
      @(negedge sys_clk);
      co = cpu_clk_out;
      @(negedge sys_clk);
      `CHK(cpu_clk_out, ~co)
      pm(1'b0, 1'b1);
      `CHK(power_mode, mcktc_pkg::PM_ACTIVE_HALT)
      co = cpu_clk_out;
      // write while halted must not land
      wreg(8'h2C, 8'h06);
      repeat (4) @(negedge sys_clk);
      `CHK(cpu_clk_out, co)
      waitev(1, 17000);
      `CHK(($time - t0) / 10, mcktc_pkg::TB_PERIOD_0)
      t0 = $time;
      repeat (3) @(negedge sys_clk);
      `CHK(power_mode, mcktc_pkg::PM_RUN)
      rreg(8'h2C, 8'hFE, 8'h86);
      pm(1'b1, 1'b0);
      `CHK(power_mode, mcktc_pkg::PM_WAIT)
      waitev(1, 33000);
      `CHK(($time - t0) / 10, mcktc_pkg::TB_PERIOD_1)
      repeat (3) @(negedge sys_clk);
      `CHK(power_mode, mcktc_pkg::PM_RUN)
      // full halt: tick disabled, only the external wake-up ends it
      wreg(8'h2C, 8'h00);
      pm(1'b0, 1'b1);
      repeat (20) @(negedge sys_clk);
      `CHK(power_mode, mcktc_pkg::PM_HALT)
      @(posedge sys_clk);
      wakeup_ext <= 1'b1;
      repeat (5) @(negedge sys_clk);
      `CHK(power_mode, mcktc_pkg::PM_RUN)
      @(posedge sys_clk);
      wakeup_ext <= 1'b0;
      results();
   end
endmodule // tb_mcktc_top
